// ===== tmr_pkg.sv
// Package: register map, field layout and codes of the 16-bit timer block.
// Assumes APB with 32-bit data; each 8-bit register takes one aligned word.
package tmr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 8;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A   = 8'h80;
  localparam logic [7:0] IDX_CTRL_B   = 8'h81;
  localparam logic [7:0] IDX_CTRL_C   = 8'h82;
  localparam logic [7:0] IDX_CNT_L    = 8'h84;
  localparam logic [7:0] IDX_CNT_H    = 8'h85;
  localparam logic [7:0] IDX_CAP_L    = 8'h86;
  localparam logic [7:0] IDX_CAP_H    = 8'h87;
  localparam logic [7:0] IDX_CMPA_L   = 8'h88;
  localparam logic [7:0] IDX_CMPA_H   = 8'h89;
  localparam logic [7:0] IDX_CMPB_L   = 8'h8a;
  localparam logic [7:0] IDX_CMPB_H   = 8'h8b;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h91;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h92;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  // Control B fields
  localparam int unsigned B_FILT   = 7;
  localparam int unsigned B_EDGE   = 6;
  localparam int unsigned B_WGM_HI = 3;
  localparam int unsigned B_CS     = 0;
  localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
  // Control A fields
  localparam int unsigned A_ACT_A   = 6;
  localparam int unsigned A_ACT_B   = 4;
  localparam int unsigned A_CAP_SRC = 2;
  localparam int unsigned A_WGM_LO  = 0;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf7;
  // Control C strobes
  localparam int unsigned C_FORCE_A = 7;
  localparam int unsigned C_FORCE_B = 6;
  // Interrupt bit layout
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_MA  = 1;
  localparam int unsigned IRQ_MB  = 2;
  localparam int unsigned IRQ_CAP = 5;
  localparam logic [7:0] IRQ_MASK = 8'h27;
  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W = 10;
  localparam logic [9:0] TAP_8    = 10'h007;
  localparam logic [9:0] TAP_64   = 10'h03f;
  localparam logic [9:0] TAP_256  = 10'h0ff;
  localparam logic [9:0] TAP_1024 = 10'h3ff;
  // Waveform modes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8    = 4'h1;
  localparam logic [3:0] WGM_PC9    = 4'h2;
  localparam logic [3:0] WGM_PC10   = 4'h3;
  localparam logic [3:0] WGM_CTC_A  = 4'h4;
  localparam logic [3:0] WGM_FP8    = 4'h5;
  localparam logic [3:0] WGM_FP9    = 4'h6;
  localparam logic [3:0] WGM_FP10   = 4'h7;
  localparam logic [3:0] WGM_PFC_I  = 4'h8;
  localparam logic [3:0] WGM_PC_I   = 4'ha;
  localparam logic [3:0] WGM_CTC_I  = 4'hc;
  localparam logic [3:0] WGM_FP_I   = 4'he;
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8   = 16'h00ff;
  localparam logic [15:0] TOP_9   = 16'h01ff;
  localparam logic [15:0] TOP_10  = 16'h03ff;
  // Compare output actions
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam int unsigned FILT_LEN = 4;
endpackage

// ===== tmr_top.sv
// Contract
// - Filter needs four equal samples to change
// - Edge select: zero falling, one rising
// - Capture copies counter and sets flag
// - Capture pin cut when capture sets top
// - Select code stops or picks prescaler tap
// - Codes 110/111 count external pin edges
// - External pin counts even driven as output
// - Force bit makes immediate match, non-PWM
// - Forced match: no interrupt, no clear
// - Force bits read zero, ignored in PWM
// - Shared high byte makes 16-bit access atomic
// - Counter write blocks next compare match
// - Compare values checked against counter on each timer tick
// - Capture source pin or comparator event
// - Forced match leaves match flag alone
// - Capture flag clears by ack or write-one
//
// File: 16-bit timer with capture, compare and APB register slave.
// Assumes APB master on clk_i and pins synchronous to clk_i.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module tmr_top (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [tmr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  input  wire logic                      capture_input_pin_i,
  input  wire logic                      comparator_event_i,
  input  wire logic                      external_count_pin_i,
  input  wire logic                      capture_ack_i,
  output logic                           waveform_out_a_o,
  output logic                           waveform_out_b_o,
  output logic                           irq_o
);
  import tmr_pkg::*;

  logic [7:0]  ctrl_a_ff, ctrl_b_ff, temp_ff, rd_hi_ff;
  logic [7:0]  stat_ff, en_ff, nxt_stat;
  logic [15:0] cnt_ff, cap_ff, cmpa_ff, cmpb_ff, top;
  logic [PRESC_W-1:0] presc_ff;
  logic [FILT_LEN-1:0] filt_sh_ff;
  logic        filt_ff, cap_prev_ff, ext_prev_ff, cmp_block_ff;
  logic        wave_a_ff, wave_b_ff, irq_ff, pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic [3:0]  mode;
  logic [2:0]  cs;
  logic        setup, wr_done, rd_done, tick, cap_in, cap_evt;
  logic        cnt_wr, force_a, force_b, match_a, match_b, at_top;
  logic        cap_src_lvl, wrap;
  logic [7:0]  idx, wbyte;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == WGM_NORMAL || m == WGM_CTC_A || m == WGM_CTC_I);
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == WGM_PFC_I || m == WGM_PC_I ||
                  m == WGM_CTC_I || m == WGM_FP_I);
  endfunction

  function automatic logic [1:0] pwm_act(input logic [1:0] act,
                                         input logic       bottom,
                                         input logic       hit,
                                         input logic       cur);
    pwm_act = {1'b0, cur};
    if (act == ACT_CLR) begin
      if (bottom) pwm_act = 2'h1;
      else if (hit) pwm_act = 2'h0;
    end else if (act == ACT_SET) begin
      if (bottom) pwm_act = 2'h0;
      else if (hit) pwm_act = 2'h1;
    end
  endfunction

  function automatic logic nonpwm_act(input logic [1:0] act,
                                      input logic       cur);
    unique case (act)
      ACT_OFF: nonpwm_act = cur;
      ACT_TOG: nonpwm_act = ~cur;
      ACT_CLR: nonpwm_act = 1'b0;
      ACT_SET: nonpwm_act = 1'b1;
    endcase
  endfunction

  assign idx     = paddr_i[IDX_W+1:2];
  assign wbyte   = pwdata_i[7:0];
  assign setup   = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_ff && pwrite_i &&
                   pstrb_i[0];
  assign rd_done = psel_i && penable_i && pready_ff && !pwrite_i;
  assign mode    = {ctrl_b_ff[B_WGM_HI+:2], ctrl_a_ff[A_WGM_LO+:2]};
  assign cs      = ctrl_b_ff[B_CS+:3];

  // Counter top by waveform mode
  always_comb begin
    unique case (mode)
      WGM_PC8, WGM_FP8:               top = TOP_8;
      WGM_PC9, WGM_FP9:               top = TOP_9;
      WGM_PC10, WGM_FP10:             top = TOP_10;
      WGM_CTC_A, 4'h9, 4'hb, 4'hf:    top = cmpa_ff;
      WGM_PFC_I, WGM_PC_I, WGM_CTC_I,
      WGM_FP_I:                       top = cap_ff;
      default:                        top = TOP_MAX;
    endcase
  end

  // Free-running prescaler
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) presc_ff <= '0;
    else presc_ff <= presc_ff + 1'b1;
  end

  // External pin edge history; pin is read whatever its direction
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ext_prev_ff <= 1'b0;
    else ext_prev_ff <= external_count_pin_i;
  end

  always_comb begin
    unique case (cs)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (presc_ff[2:0] == TAP_8[2:0]);
      CS_DIV64:    tick = (presc_ff[5:0] == TAP_64[5:0]);
      CS_DIV256:   tick = (presc_ff[7:0] == TAP_256[7:0]);
      CS_DIV1024:  tick = (presc_ff == TAP_1024);
      CS_EXT_FALL: tick = ext_prev_ff && !external_count_pin_i;
      CS_EXT_RISE: tick = !ext_prev_ff && external_count_pin_i;
    endcase
  end

  // Capture source and noise filter
  assign cap_src_lvl = ctrl_a_ff[A_CAP_SRC] ? comparator_event_i
                                            : capture_input_pin_i;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_sh_ff <= '0;
      filt_ff    <= 1'b0;
    end else begin
      filt_sh_ff <= {filt_sh_ff[FILT_LEN-2:0], cap_src_lvl};
      if (&filt_sh_ff) filt_ff <= 1'b1;
      else if (~|filt_sh_ff) filt_ff <= 1'b0;
    end
  end

  assign cap_in = ctrl_b_ff[B_FILT] ? filt_ff : cap_src_lvl;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cap_prev_ff <= 1'b0;
    else cap_prev_ff <= cap_in;
  end

  assign cap_evt = !cap_is_top(mode) &&
                   (ctrl_b_ff[B_EDGE] ? (cap_in && !cap_prev_ff)
                                      : (!cap_in && cap_prev_ff));

  // Bus-side decodes, counter top and wrap, compare matches
  assign cnt_wr  = wr_done && idx == IDX_CNT_L;
  assign force_a = wr_done && idx == IDX_CTRL_C &&
                   wbyte[C_FORCE_A] && !is_pwm(mode);
  assign force_b = wr_done && idx == IDX_CTRL_C &&
                   wbyte[C_FORCE_B] && !is_pwm(mode);
  assign at_top  = (cnt_ff == top);
  assign wrap    = tick && at_top;
  assign match_a = tick && !cmp_block_ff && cnt_ff == cmpa_ff;
  assign match_b = tick && !cmp_block_ff && cnt_ff == cmpb_ff;

  // Counter; software write wins over counting
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_ff <= RESET_WORD;
    else if (cnt_wr) cnt_ff <= {temp_ff, wbyte};
    else if (wrap) cnt_ff <= RESET_WORD;
    else if (tick) cnt_ff <= cnt_ff + 1'b1;
  end

  // Counter write masks matches on the next timer tick
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cmp_block_ff <= 1'b0;
    else if (cnt_wr) cmp_block_ff <= 1'b1;
    else if (tick) cmp_block_ff <= 1'b0;
  end

  // Capture register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cap_ff <= RESET_WORD;
    else if (cap_evt) cap_ff <= cnt_ff;
    else if (wr_done && idx == IDX_CAP_L) cap_ff <= {temp_ff, wbyte};
  end

  // Compare registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmpa_ff <= RESET_WORD;
      cmpb_ff <= RESET_WORD;
    end else if (wr_done && idx == IDX_CMPA_L) begin
      cmpa_ff <= {temp_ff, wbyte};
    end else if (wr_done && idx == IDX_CMPB_L) begin
      cmpb_ff <= {temp_ff, wbyte};
    end
  end

  // Control registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_a_ff <= RESET_BYTE;
      ctrl_b_ff <= RESET_BYTE;
      en_ff     <= RESET_BYTE;
    end else if (wr_done) begin
      if (idx == IDX_CTRL_A) ctrl_a_ff <= wbyte & CTRL_A_WMASK;
      if (idx == IDX_CTRL_B) ctrl_b_ff <= wbyte & CTRL_B_WMASK;
      if (idx == IDX_IRQ_EN) en_ff <= wbyte & IRQ_MASK;
    end
  end

  // Shared high-byte buffer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) temp_ff <= RESET_BYTE;
    else if (wr_done && (idx == IDX_CNT_H || idx == IDX_CAP_H ||
                         idx == IDX_CMPA_H || idx == IDX_CMPB_H))
      temp_ff <= wbyte;
    else if (rd_done && (idx == IDX_CNT_L || idx == IDX_CAP_L))
      temp_ff <= rd_hi_ff;
  end

  // Waveform outputs; forced match uses the same action table
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    logic [1:0] pa;
    logic [1:0] pb;
    if (!arst_n_i) begin
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
    end else if (is_pwm(mode)) begin
      pa = pwm_act(ctrl_a_ff[A_ACT_A+:2], wrap, match_a, wave_a_ff);
      pb = pwm_act(ctrl_a_ff[A_ACT_B+:2], wrap, match_b, wave_b_ff);
      wave_a_ff <= pa[0];
      wave_b_ff <= pb[0];
    end else begin
      if (match_a || force_a)
        wave_a_ff <= nonpwm_act(ctrl_a_ff[A_ACT_A+:2], wave_a_ff);
      if (match_b || force_b)
        wave_b_ff <= nonpwm_act(ctrl_a_ff[A_ACT_B+:2], wave_b_ff);
    end
  end

  // Sticky status; set beats clear, forced matches never set flags
  always_comb begin
    logic [7:0] clr;
    logic [7:0] set;
    clr = '0;
    set = '0;
    if (wr_done && idx == IDX_IRQ_CLR) clr = wbyte & IRQ_MASK;
    if (capture_ack_i) clr[IRQ_CAP] = 1'b1;
    set[IRQ_CAP] = cap_evt || (cap_is_top(mode) && wrap);
    set[IRQ_MA]  = match_a;
    set[IRQ_MB]  = match_b;
    set[IRQ_OVF] = wrap;
    nxt_stat = ((stat_ff & ~clr) | set) & IRQ_MASK;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_ff <= RESET_BYTE;
      irq_ff  <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_ff  <= |(stat_ff & en_ff);
    end
  end

  // APB slave: answer one cycle after setup
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
      rd_hi_ff   <= RESET_BYTE;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
      if (setup) begin
        unique case (idx)
          IDX_CTRL_A:   prdata_ff[7:0] <= ctrl_a_ff;
          IDX_CTRL_B:   prdata_ff[7:0] <= ctrl_b_ff;
          IDX_CTRL_C:   prdata_ff[7:0] <= RESET_BYTE;
          IDX_CNT_L:    prdata_ff[7:0] <= cnt_ff[7:0];
          IDX_CNT_H:    prdata_ff[7:0] <= temp_ff;
          IDX_CAP_L:    prdata_ff[7:0] <= cap_ff[7:0];
          IDX_CAP_H:    prdata_ff[7:0] <= temp_ff;
          IDX_CMPA_L:   prdata_ff[7:0] <= cmpa_ff[7:0];
          IDX_CMPA_H:   prdata_ff[7:0] <= cmpa_ff[15:8];
          IDX_CMPB_L:   prdata_ff[7:0] <= cmpb_ff[7:0];
          IDX_CMPB_H:   prdata_ff[7:0] <= cmpb_ff[15:8];
          IDX_IRQ_STAT: prdata_ff[7:0] <= stat_ff;
          IDX_IRQ_CLR:  prdata_ff[7:0] <= RESET_BYTE;
          IDX_IRQ_EN:   prdata_ff[7:0] <= en_ff;
          default:      pslverr_ff <= 1'b1;
        endcase
        rd_hi_ff <= (idx == IDX_CAP_L) ? cap_ff[15:8] : cnt_ff[15:8];
      end
    end
  end

  assign prdata_o         = prdata_ff;
  assign pready_o         = pready_ff;
  assign pslverr_o        = pslverr_ff;
  assign waveform_out_a_o = wave_a_ff;
  assign waveform_out_b_o = wave_b_ff;
  assign irq_o            = irq_ff;
endmodule
`default_nettype wire

// ===== tmr_top_asserts.sv
// Checker for the timer block: APB answer timing and read-back values.
// Assumes it is bound to tmr_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module tmr_top_asserts
  import tmr_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [tmr_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               prdata_o,
  input  wire logic                      pready_o,
  input  wire logic                      pslverr_o,
  input  wire logic                      irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_ready_after_setup: assert property (
    psel_i && !penable_i |=> pready_o && psel_i && penable_i)
    else $error("ready missing after setup");
  chk_ready_one_cycle: assert property (
    pready_o |=> !pready_o) else $error("ready held too long");
  chk_err_with_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  chk_upper_rdata_zero: assert property (
    pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper data set");
  chk_force_reads_zero: assert property (
    pready_o && !pwrite_i && paddr_i[9:2] == IDX_CTRL_C |-> prdata_o == 32'h0)
    else $error("force bits read nonzero");
  chk_reserved_bit_zero: assert property (
    pready_o && !pwrite_i && paddr_i[9:2] == IDX_CTRL_B |-> !prdata_o[5])
    else $error("reserved bit read one");
  chk_mapped_no_err: assert property (
    pready_o && paddr_i[9:2] == IDX_CMPA_L |-> !pslverr_o)
    else $error("error on mapped register");
  chk_irq_quiet_reset: assert property (
    $rose(arst_n_i) |-> !irq_o ##1 !irq_o) else $error("irq after reset");
endmodule
bind tmr_top tmr_top_asserts chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_o(irq_o));
`default_nettype wire

// ===== test_timer16_capture_compare_ctrl.sv
// Testbench for the timer block: register sequences over APB.
// Assumes tmr_top with a one-cycle APB answer and pins sampled on clk_i.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  error_cnt++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module test_timer16_capture_compare_ctrl;
  import tmr_pkg::*;
  logic        clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, cap_pin = 0, cmp_ev = 0, ext_pin = 0, ack = 0;
  logic [11:0] paddr_i = '0;
  logic [3:0]  pstrb_i = 4'h1;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic        pready_o, pslverr_o, wa, wb, irq_o, last_err;
  logic [7:0]  rd_v;
  logic [15:0] w16;
  int          error_cnt = 0, compares = 0;
  logic [7:0]  rst_idx [6] = '{IDX_CTRL_B, IDX_CTRL_C, IDX_CMPA_L,
                               IDX_CMPA_H, IDX_CMPB_L, IDX_CMPB_H};
  always #2 clk_i = ~clk_i;
  tmr_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .capture_input_pin_i(cap_pin), .comparator_event_i(cmp_ev),
    .external_count_pin_i(ext_pin), .capture_ack_i(ack),
    .waveform_out_a_o(wa), .waveform_out_b_o(wb), .irq_o(irq_o));
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
    paddr_i <= {2'b00, idx, 2'b00}; pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Answer is taken at the rising edge that samples ready high
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      print_verdict();
    end else begin
      rd_v = prdata_o[7:0];
      last_err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    `CHK("reg", exp, rd_v)
  endtask
  // High byte through the shared temp first, then the low byte
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] lo, input logic [15:0] exp);
    xfer(1'b0, lo, 8'h00);
    w16[7:0] = rd_v;
    xfer(1'b0, lo + 8'h1, 8'h00);
    w16[15:8] = rd_v;
    `CHK("reg16", exp, w16)
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 200 && irq_o !== 1'b1; n++) @(negedge clk_i);
    `CHK("irq", 1'b1, irq_o)
  endtask
  task automatic pulse_ext(input int k);
    repeat (k) begin
      ext_pin <= 1'b1; repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0; repeat (4) @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    foreach (rst_idx[i]) rd(rst_idx[i], RESET_BYTE);
    wr(IDX_CTRL_B, 8'h20); rd(IDX_CTRL_B, 8'h00);
    wr(IDX_CTRL_C, 8'hc0); rd(IDX_CTRL_C, 8'h00);
    xfer(1'b0, 8'hff, 8'h00); `CHK("unmapped", 1'b1, last_err)
    // Low byte write moves the buffered high byte along
    wr16(IDX_CMPA_L, 16'h1234); wr(IDX_CMPA_H, 8'hab);
    rd(IDX_CMPA_H, 8'h12); rd(IDX_CMPA_L, 8'h34);
    wr16(IDX_CMPB_L, 16'h5678); rd(IDX_CMPB_H, 8'h56);
    // Write without the low byte strobe is dropped
    pstrb_i <= 4'h0; wr(IDX_CTRL_B, 8'h07);
    pstrb_i <= 4'h1; rd(IDX_CTRL_B, 8'h00);
    // External pin edges, rising then falling
    wr16(IDX_CNT_L, 16'h0000); wr(IDX_CTRL_B, {5'h0, CS_EXT_RISE});
    pulse_ext(3); wr(IDX_CTRL_B, {5'h0, CS_STOP});
    rd16(IDX_CNT_L, 16'h0003);
    wr(IDX_CTRL_B, {5'h0, CS_EXT_FALL}); pulse_ext(2);
    wr(IDX_CTRL_B, {5'h0, CS_STOP}); repeat (20) @(posedge clk_i);
    rd16(IDX_CNT_L, 16'h0005);
    // Capture on rising then falling edge, wrong edge ignored
    wr16(IDX_CNT_L, 16'h4321); wr(IDX_IRQ_EN, 8'h20); wr(IDX_CTRL_B, 8'h40);
    cap_pin <= 1'b1; wait_irq();
    rd16(IDX_CAP_L, 16'h4321); rd(IDX_IRQ_STAT, 8'h20);
    wr(IDX_IRQ_CLR, 8'h20); cap_pin <= 1'b0; repeat (10) @(posedge clk_i);
    `CHK("irq_fall_ignored", 1'b0, irq_o)
    wr(IDX_CTRL_B, 8'h00); cap_pin <= 1'b1; repeat (10) @(posedge clk_i);
    `CHK("irq_rise_ignored", 1'b0, irq_o)
    cap_pin <= 1'b0; wait_irq();
    ack <= 1'b1; @(posedge clk_i); ack <= 1'b0; repeat (3) @(posedge clk_i);
    `CHK("irq_ack", 1'b0, irq_o)
    wr(IDX_CTRL_A, 8'h04); wr(IDX_CTRL_B, 8'h40); cmp_ev <= 1'b1;
    wait_irq();
    cmp_ev <= 1'b0; wr(IDX_IRQ_CLR, 8'h20); wr(IDX_CTRL_A, 8'h00);
    // Filter drops a three-sample glitch
    wr(IDX_CTRL_B, 8'hc0); cap_pin <= 1'b1; repeat (3) @(posedge clk_i);
    cap_pin <= 1'b0; repeat (10) @(posedge clk_i);
    `CHK("irq_glitch", 1'b0, irq_o)
    cap_pin <= 1'b1; wait_irq();
    wr(IDX_IRQ_CLR, 8'h20); cap_pin <= 1'b0;
    wr(IDX_CTRL_B, 8'h58); repeat (4) @(posedge clk_i);
    cap_pin <= 1'b1; repeat (10) @(posedge clk_i);
    rd(IDX_IRQ_STAT, 8'h00); cap_pin <= 1'b0;
    // Forced compares: outputs move outside PWM, no flag, no clear
    wr(IDX_CTRL_B, 8'h00); wr(IDX_IRQ_EN, IRQ_MASK); wr(IDX_CTRL_A, 8'h70);
    wr(IDX_CTRL_C, 8'hc0); repeat (3) @(posedge clk_i);
    `CHK("out_a", 1'b1, wa) `CHK("out_b", 1'b1, wb)
    `CHK("irq_force", 1'b0, irq_o) rd(IDX_IRQ_STAT, 8'h00);
    wr(IDX_CTRL_B, 8'h08); wr(IDX_CTRL_C, 8'h80); repeat (3) @(posedge clk_i);
    `CHK("out_a_ctc", 1'b0, wa) rd16(IDX_CNT_L, 16'h4321);
    wr(IDX_CTRL_A, 8'h71); wr(IDX_CTRL_C, 8'hc0); repeat (3) @(posedge clk_i);
    `CHK("out_a_pwm", 1'b0, wa) `CHK("out_b_pwm", 1'b1, wb)
    wr(IDX_CTRL_A, 8'h00); wr(IDX_CTRL_B, 8'h00);
    // Real match, then a counter write that blocks it
    wr(IDX_IRQ_CLR, IRQ_MASK); wr16(IDX_CMPA_L, 16'h0040);
    wr16(IDX_CNT_L, 16'h0000); wr(IDX_CTRL_B, {5'h0, CS_DIV1});
    wait_irq(); wr(IDX_CTRL_B, 8'h00); rd(IDX_IRQ_STAT, 8'h02);
    wr(IDX_IRQ_CLR, 8'h02); wr(IDX_CTRL_B, {5'h0, CS_DIV1});
    wr16(IDX_CNT_L, 16'h0040); repeat (4) @(posedge clk_i);
    wr(IDX_CTRL_B, 8'h00); rd(IDX_IRQ_STAT, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
